// ==== inc/tmr_pkg.sv ====
package tmr_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] TMR_OFS_COUNT = 8'h00; // Count register, read/write
	localparam logic [7:0] TMR_OFS_OPTION = 8'h04; // Source, edge, assignment and rate
	localparam logic [7:0] TMR_OFS_IRQ_CTRL = 8'h08; // Interrupt control register
	localparam logic [7:0] TMR_OFS_STATUS = 8'h0c; // Sticky event status, read only
	localparam logic [7:0] TMR_OFS_CLEAR = 8'h10; // Write one to clear status
	localparam logic [7:0] TMR_OFS_ENABLE = 8'h14; // Interrupt enable, status layout

	// Option register field positions
	localparam int TMR_OPT_CSS = 5; // Clock source select
	localparam int TMR_OPT_EDGE = 4; // Source edge select
	localparam int TMR_OPT_ASSIGN = 3; // Prescaler assignment, one means watchdog
	localparam int TMR_OPT_RATE_HI = 2; // Top bit of the rate field
	localparam int TMR_OPT_RATE_LO = 0; // Low bit of the rate field

	// Interrupt control field positions
	localparam int TMR_IRQ_EN_BIT = 5; // Overflow interrupt enable
	localparam int TMR_IRQ_FLAG_BIT = 2; // Overflow flag, also its status bit

	// Values after reset, and the count's top value before a wrap
	localparam logic [7:0] TMR_OPTION_RST = 8'hff;
	localparam logic [7:0] TMR_COUNT_RST = 8'h00;
	localparam logic [7:0] TMR_COUNT_MAX = 8'hff;

	// Timing: the clock is the oscillator, four phases make one instruction cycle
	localparam int TMR_OSC_PERIOD_NS = 4;
	localparam int TMR_PHASES = 16 / TMR_OSC_PERIOD_NS;
	localparam logic [1:0] TMR_Q2 = 2'h1; // Phase index of the second phase clock
	localparam logic [1:0] TMR_Q4 = 2'h3; // Phase index of the fourth phase clock
	localparam logic [1:0] TMR_HOLD_CYCLES = 2'h2; // Increment hold-off after a write

	// AXI responses
	localparam logic [1:0] TMR_RESP_OKAY = 2'h0;
	localparam logic [1:0] TMR_RESP_SLVERR = 2'h2;
endpackage

// ==== inc/tmr_link_if.sv ====
`timescale 1ns/1ps
// Signals between the counter core, the prescaler and the phase synchroniser
interface tmr_link_if;
	logic src_level; // Count source level, qualifying edge is its rise
	logic pre_clr; // Clear the prescaler count
	logic [2:0] rate; // Prescale rate field
	logic assign_wdt; // Prescaler belongs to the watchdog
	logic wdt_tick; // Watchdog oscillator tick
	logic pre_out; // Prescaler output level toward the synchroniser
	logic pre_tap; // Selected prescaler stage, watchdog side
	logic run; // Low while asleep
	logic phase_hi; // High during the third and fourth phases
	logic inc; // One-cycle increment request
	logic cyc_end; // One-cycle pulse after each instruction cycle
	modport pre (input src_level, pre_clr, rate, assign_wdt, wdt_tick,
		output pre_out, pre_tap);
	modport sync (input pre_out, run, output phase_hi, inc, cyc_end);
	modport core (output src_level, pre_clr, rate, assign_wdt, wdt_tick, run,
		input pre_out, pre_tap, phase_hi, inc, cyc_end);
endinterface

// ==== design/tmr_prescaler.sv ====
`timescale 1ns/1ps
// Shared 8-bit prescaler; each stage toggles on the fall of the one before
module tmr_prescaler (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link to the core
	tmr_link_if.pre lnk
);
	logic [7:0] cnt_reg; // Ripple stages, not visible to software
	logic prev_reg; // Source level one cycle ago
	logic rise; // Qualifying input event

	// Watchdog ticks feed it when assigned there, else source rises
	assign rise = lnk.assign_wdt ? lnk.wdt_tick : (lnk.src_level & ~prev_reg);

	// Edge memory for the source level
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			prev_reg <= 1'b0;
		else
			prev_reg <= lnk.src_level;
	end

	// Binary count equals the ripple chain, so every stage is a square wave
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			cnt_reg <= 8'h00;
		else if (lnk.pre_clr)
			cnt_reg <= 8'h00;
		else if (rise)
			cnt_reg <= cnt_reg + 8'h01;
	end

	// Stage n gives 1:2^(n+1); the counter bypasses it when it is assigned to the watchdog
	assign lnk.pre_tap = cnt_reg[lnk.rate];
	assign lnk.pre_out = lnk.assign_wdt ? lnk.src_level : cnt_reg[lnk.rate];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_pre_clear;
		lnk.pre_clr |=> (cnt_reg == 8'h00);
	endproperty
	a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");
endmodule

// ==== design/tmr_qsync.sv ====
`timescale 1ns/1ps
// Phase generator and two-phase sampler of the prescaler output
module tmr_qsync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link to the core
	tmr_link_if.sync lnk
);
	logic [1:0] phase_reg; // Q1..Q4 as 0..3
	logic samp_q2_reg; // Sample taken at the second phase
	logic samp_q4_reg; // Sample taken at the fourth phase
	logic primed_reg; // First Q4 after reset has passed
	logic inc_reg; // Increment pulse
	logic end_reg; // Instruction cycle end pulse

	// Free-running phase clocks; the source level rises once per cycle
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			phase_reg <= 2'h0;
		else
			phase_reg <= phase_reg + 2'h1;
	end
	assign lnk.phase_hi = phase_reg[1];

	// Sampling on Q2 then Q4 bounds the needed high and low time to two periods
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			samp_q2_reg <= 1'b0;
			samp_q4_reg <= 1'b0;
		end
		else if (phase_reg == tmr_pkg::TMR_Q2)
			samp_q2_reg <= lnk.pre_out;
		else if (phase_reg == tmr_pkg::TMR_Q4)
			samp_q4_reg <= lnk.pre_out;
	end

	// Increment on a sampled rise; asleep, the sampler keeps sampling but no increment is issued
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			inc_reg <= 1'b0;
			end_reg <= 1'b0;
			primed_reg <= 1'b0;
		end
		else
		begin
			end_reg <= (phase_reg == tmr_pkg::TMR_Q4);
			// Rise between the last Q4 and this Q2 sample, or between Q2 and now
			inc_reg <= (phase_reg == tmr_pkg::TMR_Q4) && lnk.run && primed_reg
				&& ((samp_q2_reg && !samp_q4_reg) || (!samp_q2_reg && lnk.pre_out));
			// The first Q4 only loads, so a reset level is never taken as an edge
			if (phase_reg == tmr_pkg::TMR_Q4)
				primed_reg <= 1'b1;
		end
	end
	assign lnk.inc = inc_reg;
	assign lnk.cyc_end = end_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_inc_at_end;
		lnk.inc |-> lnk.cyc_end;
	endproperty
	a_inc_at_end: assert property (p_inc_at_end) else $error("increment off the Q4 slot");
endmodule

// ==== design/tmr_top.sv ====
`timescale 1ns/1ps
// Contract
// - 8-bit count wraps FF to 00, sets flag
// - Timer mode counts every instruction cycle when unprescaled
// - Counter mode counts external edges, edge selectable
// - Count write holds increments two instruction cycles
// - Prescaler serves counter or watchdog, never both
// - Rate field 1:2..1:256; watchdog assignment gives 1:1
// - Prescaler count is not software accessible
// - Interrupt request only while enable bit set
// - Counter stops during sleep
// - External input sampled after prescaler at Q2,Q4
// - Prescaler is ripple style, symmetric output
// - Count updates a latency after external edge
// - Count write resets a counter-owned prescaler, watchdog clear a watchdog-owned one
module tmr_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Count pin and device state
	input wire logic external_count_input,
	input wire logic sleep_mode,
	// Watchdog side
	input wire logic wdt_clear,
	input wire logic wdt_osc_tick,
	output logic wdt_post_level,
	// Interrupt
	output logic irq
);
	tmr_link_if lnk ();

	logic [7:0] count_reg; // Count register
	logic [7:0] option_reg; // Source, edge, assignment, rate
	logic overflow_flag_reg; // Sticky overflow flag
	logic overflow_irq_enable_reg; // Interrupt enable
	logic [1:0] hold_reg; // Instruction cycles left in the hold-off
	logic irq_reg; // Registered interrupt output
	logic wdt_post_reg; // Registered watchdog stage
	logic aw_have_reg; // Write address held
	logic w_have_reg; // Write data held
	logic [7:0] aw_addr_reg; // Held write address
	logic [31:0] w_data_reg; // Held write data
	logic w_lane0_reg; // Low byte lane enabled
	logic bvalid_reg; // Write response pending
	logic [1:0] bresp_reg; // Write response code
	logic awready_reg; // Write address ready
	logic wready_reg; // Write data ready
	logic arready_reg; // Read address ready
	logic rvalid_reg; // Read data pending
	logic [31:0] rdata_reg; // Read data
	logic [1:0] rresp_reg; // Read response code
	logic do_write; // Both halves held, response slot free
	logic wr_count; // Write to the count register
	logic wr_option; // Write to the option register
	logic wr_irq_ctrl; // Write to interrupt control
	logic wr_clear; // Write to the clear register
	logic wr_enable; // Write to the enable register
	logic count_step; // Increment accepted this cycle
	logic flag_next; // Next overflow flag
	logic enable_next; // Next interrupt enable

	// Write decode, only the low byte lane holds register bits
	assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wr_count = do_write && w_lane0_reg && (aw_addr_reg == tmr_pkg::TMR_OFS_COUNT);
	assign wr_option = do_write && w_lane0_reg && (aw_addr_reg == tmr_pkg::TMR_OFS_OPTION);
	assign wr_irq_ctrl = do_write && w_lane0_reg
		&& (aw_addr_reg == tmr_pkg::TMR_OFS_IRQ_CTRL);
	assign wr_clear = do_write && w_lane0_reg && (aw_addr_reg == tmr_pkg::TMR_OFS_CLEAR);
	assign wr_enable = do_write && w_lane0_reg && (aw_addr_reg == tmr_pkg::TMR_OFS_ENABLE);

	// Decides whether a byte address is one of ours
	function automatic logic tmr_mapped(input logic [7:0] addr);
		tmr_mapped = (addr == tmr_pkg::TMR_OFS_COUNT) || (addr == tmr_pkg::TMR_OFS_OPTION)
			|| (addr == tmr_pkg::TMR_OFS_IRQ_CTRL) || (addr == tmr_pkg::TMR_OFS_STATUS)
			|| (addr == tmr_pkg::TMR_OFS_CLEAR) || (addr == tmr_pkg::TMR_OFS_ENABLE);
	endfunction

	// Write address and data are taken in either order and held
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_lane0_reg <= 1'b0;
		end
		else if (do_write)
		begin
			// Both freed at once; ready returns once the response is accepted
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && awready_reg)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && wready_reg)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_lane0_reg <= s_axi_wstrb[0];
			end
		end
	end

	// Write response, unmapped addresses answer SLVERR
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= tmr_pkg::TMR_RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= tmr_mapped(aw_addr_reg) ? tmr_pkg::TMR_RESP_OKAY
				: tmr_pkg::TMR_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end
	// Readies are flops: low from the take of a half until its response is accepted
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
		end
		else
		begin
			if (s_axi_awvalid && awready_reg)
				awready_reg <= 1'b0;
			else if (bvalid_reg && s_axi_bready)
				awready_reg <= 1'b1;
			if (s_axi_wvalid && wready_reg)
				wready_reg <= 1'b0;
			else if (bvalid_reg && s_axi_bready)
				wready_reg <= 1'b1;
		end
	end
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Read channel; the prescaler count has no address at all
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= tmr_pkg::TMR_RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_reg)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= tmr_mapped({s_axi_araddr[7:2], 2'h0}) ? tmr_pkg::TMR_RESP_OKAY
				: tmr_pkg::TMR_RESP_SLVERR;
			case ({s_axi_araddr[7:2], 2'h0})
				tmr_pkg::TMR_OFS_COUNT: rdata_reg <= {24'h00_0000, count_reg};
				tmr_pkg::TMR_OFS_OPTION: rdata_reg <= {24'h00_0000, option_reg};
				tmr_pkg::TMR_OFS_IRQ_CTRL:
					rdata_reg <= (32'(overflow_irq_enable_reg) << tmr_pkg::TMR_IRQ_EN_BIT)
						| (32'(overflow_flag_reg) << tmr_pkg::TMR_IRQ_FLAG_BIT);
				tmr_pkg::TMR_OFS_STATUS:
					rdata_reg <= 32'(overflow_flag_reg) << tmr_pkg::TMR_IRQ_FLAG_BIT;
				tmr_pkg::TMR_OFS_ENABLE:
					rdata_reg <= 32'(overflow_irq_enable_reg) << tmr_pkg::TMR_IRQ_FLAG_BIT;
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Option register; switching assignment on the fly is allowed
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			option_reg <= tmr_pkg::TMR_OPTION_RST;
		else if (wr_option)
			option_reg <= w_data_reg[7:0];
	end

	// Count source: phase clock in timer mode, chosen pin edge in counter mode
	always_comb
	begin
		if (option_reg[tmr_pkg::TMR_OPT_CSS])
			lnk.src_level = external_count_input ^ option_reg[tmr_pkg::TMR_OPT_EDGE];
		else
			lnk.src_level = lnk.phase_hi && !sleep_mode;
	end
	assign lnk.rate = option_reg[tmr_pkg::TMR_OPT_RATE_HI:tmr_pkg::TMR_OPT_RATE_LO];
	assign lnk.assign_wdt = option_reg[tmr_pkg::TMR_OPT_ASSIGN];
	assign lnk.wdt_tick = wdt_osc_tick;
	assign lnk.run = !sleep_mode;
	// A count write clears only a counter-owned prescaler
	assign lnk.pre_clr = lnk.assign_wdt ? wdt_clear : wr_count;

	tmr_prescaler u_pre (
		.clk(clk),
		.rst_b(rst_b),
		.lnk(lnk)
	);

	tmr_qsync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.lnk(lnk)
	);

	// Increments are dropped during the hold-off and while asleep
	assign count_step = lnk.inc && (hold_reg == 2'h0) && !sleep_mode;

	// Hold-off counts whole instruction cycles after a count write
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			hold_reg <= 2'h0;
		else if (wr_count)
			hold_reg <= tmr_pkg::TMR_HOLD_CYCLES;
		else if (lnk.cyc_end && hold_reg != 2'h0)
			hold_reg <= hold_reg - 2'h1;
	end

	// Count register, a write beats a same-cycle increment
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			count_reg <= tmr_pkg::TMR_COUNT_RST;
		else if (wr_count)
			count_reg <= w_data_reg[7:0];
		else if (count_step)
			count_reg <= count_reg + 8'h01;
	end

	// Flag: wrap sets it, software clears it, and a set beats a clear
	always_comb
	begin
		flag_next = overflow_flag_reg;
		if (wr_clear && w_data_reg[tmr_pkg::TMR_IRQ_FLAG_BIT])
			flag_next = 1'b0;
		if (count_step && count_reg == tmr_pkg::TMR_COUNT_MAX)
			flag_next = 1'b1;
	end

	// Enable lives in the control register and aliases in the enable register
	always_comb
	begin
		enable_next = overflow_irq_enable_reg;
		if (wr_irq_ctrl)
			enable_next = w_data_reg[tmr_pkg::TMR_IRQ_EN_BIT];
		else if (wr_enable)
			enable_next = w_data_reg[tmr_pkg::TMR_IRQ_FLAG_BIT];
	end

	// Flag, enable and the registered interrupt level
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			overflow_flag_reg <= 1'b0;
			overflow_irq_enable_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
		else
		begin
			overflow_flag_reg <= flag_next;
			overflow_irq_enable_reg <= enable_next;
			irq_reg <= flag_next && enable_next;
		end
	end
	assign irq = irq_reg;

	// Watchdog sees the selected stage only while it owns the prescaler
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wdt_post_reg <= 1'b0;
		else
			wdt_post_reg <= lnk.assign_wdt && lnk.pre_tap;
	end
	assign wdt_post_level = wdt_post_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_wrap;
		count_step && (count_reg == tmr_pkg::TMR_COUNT_MAX) && !wr_count;
	endsequence
	sequence s_held;
		(hold_reg == tmr_pkg::TMR_HOLD_CYCLES) && (count_reg == $past(w_data_reg[7:0]));
	endsequence

	property p_wrap_sets_flag;
		s_wrap |=> (count_reg == 8'h00) && overflow_flag_reg;
	endproperty
	a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap lost");
	property p_write_holds;
		wr_count |=> s_held;
	endproperty
	a_write_holds: assert property (p_write_holds) else $error("hold-off not armed");
	property p_hold_freezes;
		(hold_reg != 2'h0) && !wr_count |=> $stable(count_reg);
	endproperty
	a_hold_freezes: assert property (p_hold_freezes) else $error("count moved in hold");
	property p_flag_sticky;
		overflow_flag_reg && !wr_clear |=> overflow_flag_reg;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
	property p_irq_mask;
		irq |-> overflow_flag_reg && overflow_irq_enable_reg;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
	property p_sleep_stops;
		sleep_mode && !wr_count |=> $stable(count_reg);
	endproperty
	a_sleep_stops: assert property (p_sleep_stops) else $error("count ran asleep");
	property p_timer_rate;
		!option_reg[tmr_pkg::TMR_OPT_CSS] && lnk.assign_wdt && lnk.inc |=> !lnk.inc [*3];
	endproperty
	a_timer_rate: assert property (p_timer_rate) else $error("timer rate wrong");
endmodule

// ==== dv/tmr_ext_src.sv ====
`timescale 1ns/1ps
// Clock source on the count pin; pin sits at its idle level between frames
module tmr_ext_src (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Frame request
	input wire logic start,
	input wire logic [7:0] n_pulses,
	input wire logic [3:0] half,
	input wire logic idle_lvl,
	// Count pin
	output logic pin,
	output logic busy
);
	logic [7:0] left_reg; // Pulses still to send
	logic [3:0] tick_reg; // Clocks spent in this half
	logic phase_reg; // Low while away from idle
	logic [3:0] hmin; // Half period, never under two clocks

	// Shorter halves would break the pin's minimum high and low time
	assign hmin = (half < 4'h2) ? 4'h2 : half;
	assign busy = (left_reg != 8'h00);
	assign pin = (busy && !phase_reg) ? !idle_lvl : idle_lvl;

	// Each pulse leaves idle for one half, then returns for one half
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			left_reg <= 8'h00;
			tick_reg <= 4'h0;
			phase_reg <= 1'b0;
		end
		else if (start && !busy)
		begin
			left_reg <= n_pulses;
			tick_reg <= 4'h0;
			phase_reg <= 1'b0;
		end
		else if (busy)
		begin
			if (tick_reg == hmin - 4'h1)
			begin
				tick_reg <= 4'h0;
				phase_reg <= !phase_reg;
				if (phase_reg)
					left_reg <= left_reg - 8'h01;
			end
			else
				tick_reg <= tick_reg + 4'h1;
		end
	end
endmodule

// ==== dv/eight_bit_timer_counter_prescaled_bench.sv ====
`timescale 1ns/1ps
module eight_bit_timer_counter_prescaled_bench;
	// Clock, reset, bus master and pin drivers
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic sleep = 1'b0, wclr = 1'b0, tick = 1'b0, go = 1'b0, idle = 1'b0;
	logic [7:0] n_pul = 8'h00;
	logic [3:0] half = 4'h2;
	// Design answers
	logic awready, wready, bvalid, arready, rvalid, pin, busy, wdt_lvl, irq;
	logic [1:0] bresp, rresp, wr_resp;
	logic [31:0] rdata, rd_val, c0;
	logic [31:0] rnd = 32'h0000000c; // Fixed seed keeps runs repeatable
	int err_total = 0, cmp_count = 0, cyc = 0;

	tmr_top i_tmr_top (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .external_count_input(pin), .sleep_mode(sleep),
		.wdt_clear(wclr), .wdt_osc_tick(tick), .wdt_post_level(wdt_lvl), .irq(irq));
	tmr_ext_src i_tmr_ext_src (.clk(clk), .rst_b(rst_b), .start(go), .n_pulses(n_pul),
		.half(half), .idle_lvl(idle), .pin(pin), .busy(busy));

	always #2 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Clocks per increment in timer mode for an option value
	function automatic int cpi(input logic [7:0] opt);
		return opt[3] ? 4 : (8 << opt[2:0]);
	endfunction
	// One when the pin step matches the selected edge
	function automatic logic [31:0] gain(input logic fall_sel, input logic went_high);
		return {31'h0, fall_sel ^ went_high};
	endfunction

	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Write: both halves offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_t, w_t, b_t;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_t = 1'b0;
		while (!b_t)
		begin
			@(negedge clk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			wr_resp = bresp;
			@(posedge clk);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge clk);
	endtask
	// Read: count taken at the address edge; the next read's edge is wait + 3 later
	task automatic rd(input logic [7:0] a);
		logic ar_t, r_t;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_t = 1'b0;
		while (!r_t)
		begin
			@(negedge clk);
			ar_t = arvalid && arready;
			r_t = rvalid;
			rd_val = rdata;
			@(posedge clk);
			if (ar_t)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pulse(input logic [7:0] n, input logic [3:0] h);
		n_pul <= n;
		half <= h;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(negedge clk);
		while (busy)
			@(negedge clk);
		@(posedge clk);
	endtask

	// Random one-cycle watchdog ticks and clears
	always @(posedge clk)
	begin
		rnd <= xs(rnd);
		tick <= rnd[0] && !tick;
		wclr <= rnd[1] && rnd[2] && !wclr;
	end
	// Hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_total++;
			test_done;
		end
	end

	initial
	begin
		logic [7:0] o;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(tmr_pkg::TMR_OFS_COUNT);
		chk(rd_val, 32'h0);
		rd(tmr_pkg::TMR_OFS_OPTION);
		chk(rd_val, 32'hff);
		chk({31'h0, irq}, 32'h0);
		// No address reaches the prescaler count
		rd(8'h18);
		chk(rd_val, 32'h0);
		chk({30'h0, rresp}, {30'h0, tmr_pkg::TMR_RESP_SLVERR});
		wr(8'h18, 8'h55);
		chk({30'h0, wr_resp}, {30'h0, tmr_pkg::TMR_RESP_SLVERR});
		// Random writes read back before the hold-off ends
		wr(tmr_pkg::TMR_OFS_OPTION, 8'h08);
		for (int i = 0; i < 4; i++)
		begin
			o = rnd[7:0];
			wr(tmr_pkg::TMR_OFS_COUNT, o);
			chk({30'h0, wr_resp}, {30'h0, tmr_pkg::TMR_RESP_OKAY});
			rd(tmr_pkg::TMR_OFS_COUNT);
			chk(rd_val, {24'h0, o});
		end
		// Every rate, then watchdog assignment with rate 7
		for (int n = 0; n < 9; n++)
		begin
			o = (n < 8) ? n[7:0] : 8'h0f;
			wr(tmr_pkg::TMR_OFS_OPTION, o);
			wt(2 * cpi(o));
			rd(tmr_pkg::TMR_OFS_COUNT);
			c0 = rd_val;
			// The read itself adds three edges, so the window is exactly two periods
			wt(2 * cpi(o) - 3);
			rd(tmr_pkg::TMR_OFS_COUNT);
			chk((rd_val - c0) & 32'hff, 32'h2);
			if (!o[3])
				chk({31'h0, wdt_lvl}, 32'h0);
		end
		// Wrap, sticky flag, masking and clearing
		// Earlier random counts may have wrapped; start from a clean flag
		wr(tmr_pkg::TMR_OFS_COUNT, 8'h00);
		wr(tmr_pkg::TMR_OFS_CLEAR, 8'h04);
		wr(tmr_pkg::TMR_OFS_IRQ_CTRL, 8'h20);
		wr(tmr_pkg::TMR_OFS_COUNT, 8'hfe);
		rd(tmr_pkg::TMR_OFS_STATUS);
		chk(rd_val, 32'h0);
		wt(40);
		sleep <= 1'b1;
		wt(2);
		chk({31'h0, irq}, 32'h1);
		rd(tmr_pkg::TMR_OFS_STATUS);
		chk(rd_val, 32'h4);
		rd(tmr_pkg::TMR_OFS_COUNT);
		c0 = rd_val;
		wt(100);
		rd(tmr_pkg::TMR_OFS_COUNT);
		chk(rd_val, c0);
		rd(tmr_pkg::TMR_OFS_IRQ_CTRL);
		chk(rd_val, 32'h24);
		wr(tmr_pkg::TMR_OFS_IRQ_CTRL, 8'h00);
		wt(2);
		chk({31'h0, irq}, 32'h0);
		rd(tmr_pkg::TMR_OFS_ENABLE);
		chk(rd_val, 32'h0);
		wr(tmr_pkg::TMR_OFS_ENABLE, 8'h04);
		wt(2);
		chk({31'h0, irq}, 32'h1);
		wr(tmr_pkg::TMR_OFS_CLEAR, 8'h04);
		wt(2);
		chk({31'h0, irq}, 32'h0);
		rd(tmr_pkg::TMR_OFS_STATUS);
		chk(rd_val, 32'h0);
		wr(tmr_pkg::TMR_OFS_ENABLE, 8'h00);
		sleep <= 1'b0;
		// Pin counting on each edge choice, unprescaled
		for (int e = 0; e < 2; e++)
		begin
			wr(tmr_pkg::TMR_OFS_OPTION, e[0] ? 8'h38 : 8'h28);
			// Switching the edge flips the source level; let that step settle first
			wt(12);
			rd(tmr_pkg::TMR_OFS_COUNT);
			c0 = rd_val;
			pulse(8'h05, 4'h2);
			wt(12);
			rd(tmr_pkg::TMR_OFS_COUNT);
			chk((rd_val - c0) & 32'hff, 32'h5);
			idle <= 1'b1;
			wt(12);
			rd(tmr_pkg::TMR_OFS_COUNT);
			chk((rd_val - c0) & 32'hff, 32'h5 + gain(e[0], 1'b1));
			idle <= 1'b0;
			wt(12);
			rd(tmr_pkg::TMR_OFS_COUNT);
			chk((rd_val - c0) & 32'hff, 32'h6);
		end
		// Pin at 1:2; a count write clears a half-filled prescaler
		wr(tmr_pkg::TMR_OFS_OPTION, 8'h20);
		for (int k = 0; k < 2; k++)
		begin
			wr(tmr_pkg::TMR_OFS_COUNT, 8'h00);
			wt(12);
			pulse(8'h01, 4'h3);
			wt(12);
			rd(tmr_pkg::TMR_OFS_COUNT);
			chk(rd_val, 32'h1);
		end
		pulse(8'h08, 4'h2);
		wt(12);
		rd(tmr_pkg::TMR_OFS_COUNT);
		chk(rd_val, 32'h5);
		chk({31'h0, wdt_lvl}, 32'h0);
		test_done;
	end
endmodule
